// ==== rtl/irxf_pkg.sv ====
/*
 * Package for the inter-register transform, constant/page transform and
 * bit-test selector. Holds field codes, widths and condition positions.
 * Assumes a single 200 MHz clock domain and no bus.
 */
package irxf_pkg;
   localparam int IRXF_FN_W = 5;
   localparam int IRXF_SRC_W = 3;
   localparam int IRXF_KN_W = 32;
   // Function codes
   localparam logic [4:0] IRXF_FN_ADD_TRUE = 5'h19;   // 11001
   localparam logic [4:0] IRXF_FN_AND = 5'h0e;    // 01110
   localparam logic [4:0] IRXF_FN_OR = 5'h09;     // 01001
   localparam logic [4:0] IRXF_FN_NSUM = 5'h01;   // 00001
   localparam logic [4:0] IRXF_FN_ADDC = 5'h1a;   // 11010
   // Source and destination codes
   localparam logic [2:0] IRXF_SRC_PC = 3'h1;
   localparam logic [2:0] IRXF_SRC_ZERO = 3'h1;
   localparam logic [2:0] IRXF_SRC_ONES = 3'h6;
   localparam logic [2:0] IRXF_SRC_ACC = 3'h4;
   localparam logic [2:0] IRXF_SRC_Q = 3'h4;
   localparam logic [2:0] IRXF_DST_PC = 3'h1;
   localparam logic [2:0] IRXF_DST_ACC = 3'h5;
   localparam logic [2:0] IRXF_DST_Q = 3'h3;
   localparam logic [2:0] IRXF_DST_NOP = 3'h0;
   // Instruction bit positions
   localparam int IRXF_I_PROD = 8;
   localparam int IRXF_I_XOR = 9;
   localparam int IRXF_I_A = 10;
   localparam int IRXF_I_Q = 11;
   localparam int IRXF_I_M = 12;
   localparam int IRXF_I_DA = 13;
   localparam int IRXF_I_DQ = 14;
   // Bit-test positions
   localparam logic [3:0] IRXF_BT_PROT = 4'h5;
   localparam logic [3:0] IRXF_BT_DZERO = 4'ha;
   localparam logic [15:0] IRXF_ZERO16 = 16'h0000;

   typedef struct packed {
      logic [4:0] fn;
      logic [2:0] a_src;
      logic [2:0] b_src;
      logic [2:0] dst;
   } irxf_fields_s;
endpackage : irxf_pkg

// ==== rtl/irxf_bit_test.sv ====
/*
 * Sixteen-way single-bit condition selector.
 * Assumes the caller supplies conditions already polarised so that 1
 * means "execute upper micro instruction".
 */
`timescale 1ns/10ps
`default_nettype none
module irxf_bit_test import irxf_pkg::*; (
   input wire logic [15:0] cond_i,
   input wire logic [3:0] sel_i,
   output logic bit_o
);
   // Plain index; positions other than 5 and 10 come in unchanged from the top's cond_i
   assign bit_o = cond_i[sel_i]; // [RQ9]
endmodule : irxf_bit_test
`default_nettype wire

// ==== rtl/irxf_top.sv ====
/*
 * Inter-register transform decoder, constant/page transform and bit-test
 * selector, registered outputs on the micro-cycle clock.
 * Assumes the sequencer qualifies bit_test_o with its own test decode.
 */
// Operation
// RQ1: I12 zero selects origin transform path
// RQ2: I8/I9 pick function code with I12 zero
// RQ3: I12 set forces add-carry, PC, zero, PC
// RQ4: I10/I11 pick accumulator/Q or ones sources
// RQ5: Destination accumulator, Q or no-op; protect nops
// RQ6: Const transform from ground, second selector, index, micro
// RQ7: Const transform drives only when enable low
// RQ8: Enable high during clears loads zeros
// RQ9: Bit test is single-bit sixteen-way multiplexer
// RQ10: Micro register bits 28-31 select the condition
// RQ11: Test result picks upper or lower micro
// RQ12: Sequencer uses output only on bit-test command
// RQ13: Position 10 true when delta zero
// RQ14: Position 5 lower on protect fault
// RQ15: Fields presented only during transform command
`timescale 1ns/10ps
`default_nettype none
module irxf_top import irxf_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic instr_transform_cmd_i,
   input wire logic [15:0] instr_i,
   input wire logic protect_violation_i,
   input wire logic const_xform_enable_n_i,
   input wire logic [7:0] second_selector_i,
   input wire logic [15:0] index_transform_reg_i,
   input wire logic [31:0] micro_instr_reg_i,
   input wire logic [15:0] cond_i,
   output logic [4:0] fn_o,
   output logic [2:0] a_src_o,
   output logic [2:0] b_src_o,
   output logic [2:0] dst_o,
   output logic fields_valid_o,
   output logic xform_origin_path_o,
   output logic xform_nonorigin_path_o,
   output logic [31:0] kn_xform_o,
   output logic bit_test_o
);
   irxf_fields_s fld_nxt;
   irxf_fields_s fld_r;
   logic origin_w;
   logic [4:0] fn_org_w;
   logic [2:0] dst_org_w;
   logic [31:0] kn_nxt;
   logic [15:0] cond_w;
   logic bit_nxt;
   logic valid_r;
   logic org_r;
   logic nonorg_r;
   logic [31:0] kn_r;
   logic bit_r;

   // Path choice from memory-origin bit
   assign origin_w = ~instr_i[IRXF_I_M]; // [RQ1]

   // Function from product/xor bits; others don't care
   assign fn_org_w = (!instr_i[IRXF_I_PROD] && !instr_i[IRXF_I_XOR]) ? IRXF_FN_ADD_TRUE :
                     (instr_i[IRXF_I_PROD] && !instr_i[IRXF_I_XOR]) ? IRXF_FN_AND :
                     (!instr_i[IRXF_I_PROD]) ? IRXF_FN_OR : IRXF_FN_NSUM; // [RQ2] [RQ15]

   // Destination priority A over Q; protect kills register writes
   assign dst_org_w = protect_violation_i ? IRXF_DST_NOP :
                      instr_i[IRXF_I_DA] ? IRXF_DST_ACC :
                      instr_i[IRXF_I_DQ] ? IRXF_DST_Q : IRXF_DST_NOP; // [RQ5]

   // Field assembly; zeros outside the transform command
   always_comb begin
      fld_nxt = '0;
      if (instr_transform_cmd_i) begin // [RQ15]
         if (origin_w) begin
            fld_nxt.fn = fn_org_w;
            fld_nxt.a_src = instr_i[IRXF_I_A] ? IRXF_SRC_ACC : IRXF_SRC_ONES; // [RQ4]
            fld_nxt.b_src = instr_i[IRXF_I_Q] ? IRXF_SRC_Q : IRXF_SRC_ONES; // [RQ4]
            fld_nxt.dst = dst_org_w;
         end else begin
            fld_nxt.fn = IRXF_FN_ADDC; // [RQ3]
            fld_nxt.a_src = IRXF_SRC_PC; // [RQ3]
            fld_nxt.b_src = IRXF_SRC_ZERO; // [RQ3]
            fld_nxt.dst = protect_violation_i ? IRXF_DST_NOP : IRXF_DST_PC; // [RQ3]
         end
      end
   end

   // Constant/page word: ground byte on top, micro bits 24-31 at the bottom;
   // micro bits 0-7 must not leak into the K/N load
   assign kn_nxt = const_xform_enable_n_i ? 32'h0000_0000 : // [RQ7] [RQ8]
                   {8'h00, second_selector_i, index_transform_reg_i[15:8],
                    micro_instr_reg_i[7:0]}; // [RQ6]

   // Conditions: position 5 inverted so 1 means upper; 10 is delta zero
   always_comb begin
      cond_w = cond_i;
      cond_w[IRXF_BT_PROT] = ~cond_i[IRXF_BT_PROT]; // [RQ14]
      cond_w[IRXF_BT_DZERO] = (index_transform_reg_i[15:8] == 8'h00); // [RQ13]
   end

   // Select code is micro bits 28-31 (low nibble in this numbering)
   irxf_bit_test u_bit_test (
      .cond_i(cond_w),
      .sel_i(micro_instr_reg_i[3:0]), // [RQ10]
      .bit_o(bit_nxt)
   );

   // Output flops; one-cycle latency keeps outputs glitch free
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fld_r <= '0;
         valid_r <= 1'b0;
         org_r <= 1'b0;
         nonorg_r <= 1'b0;
         kn_r <= '0;
         bit_r <= 1'b0;
      end else begin
         fld_r <= fld_nxt;
         valid_r <= instr_transform_cmd_i;
         org_r <= instr_transform_cmd_i & origin_w;
         nonorg_r <= instr_transform_cmd_i & ~origin_w;
         kn_r <= kn_nxt;
         bit_r <= bit_nxt; // [RQ11] [RQ12]
      end
   end

   assign fn_o = fld_r.fn;
   assign a_src_o = fld_r.a_src;
   assign b_src_o = fld_r.b_src;
   assign dst_o = fld_r.dst;
   assign fields_valid_o = valid_r;
   assign xform_origin_path_o = org_r;
   assign xform_nonorigin_path_o = nonorg_r;
   assign kn_xform_o = kn_r;
   assign bit_test_o = bit_r;

   property p_rq3;
      @(posedge clk_i) disable iff (!rst_n_i)
      (instr_transform_cmd_i && instr_i[IRXF_I_M]) |=> (fn_o == IRXF_FN_ADDC && a_src_o == 3'h1);
   endproperty
   a_rq3: assert property (p_rq3) else $error("forced add-carry missing"); // [RQ3]

   property p_rq2;
      @(posedge clk_i) disable iff (!rst_n_i)
      (instr_transform_cmd_i && !instr_i[12] && instr_i[9:8] == 2'b01) |=> fn_o == 5'h0e;
   endproperty
   a_rq2: assert property (p_rq2) else $error("logical product code wrong"); // [RQ2]

   property p_rq1;
      @(posedge clk_i) disable iff (!rst_n_i)
      instr_transform_cmd_i |=> (xform_origin_path_o != xform_nonorigin_path_o);
   endproperty
   a_rq1: assert property (p_rq1) else $error("path select wrong"); // [RQ1]

   property p_rq4;
      @(posedge clk_i) disable iff (!rst_n_i)
      (instr_transform_cmd_i && !instr_i[12] && !instr_i[10]) |=> a_src_o == 3'h6;
   endproperty
   a_rq4: assert property (p_rq4) else $error("ones source missing"); // [RQ4]

   property p_rq5;
      @(posedge clk_i) disable iff (!rst_n_i)
      (instr_transform_cmd_i && protect_violation_i) |=> dst_o == 3'h0;
   endproperty
   a_rq5: assert property (p_rq5) else $error("protect did not nop"); // [RQ5]

   property p_rq8;
      @(posedge clk_i) disable iff (!rst_n_i)
      const_xform_enable_n_i |=> kn_xform_o == 32'h0000_0000;
   endproperty
   a_rq8: assert property (p_rq8) else $error("clear not zero"); // [RQ8]

   property p_rq15;
      @(posedge clk_i) disable iff (!rst_n_i)
      !instr_transform_cmd_i |=> (fn_o == 5'h00 && !fields_valid_o);
   endproperty
   a_rq15: assert property (p_rq15) else $error("fields leaked"); // [RQ15]

   property p_rq13;
      @(posedge clk_i) disable iff (!rst_n_i)
      (micro_instr_reg_i[3:0] == 4'ha && index_transform_reg_i[15:8] == 8'h00) |=> bit_test_o;
   endproperty
   a_rq13: assert property (p_rq13) else $error("delta zero test wrong"); // [RQ13]

   property p_rq14;
      @(posedge clk_i) disable iff (!rst_n_i)
      (micro_instr_reg_i[3:0] == 4'h5 && cond_i[5]) |=> !bit_test_o;
   endproperty
   a_rq14: assert property (p_rq14) else $error("protect test wrong"); // [RQ14]

   property p_rq14_clear;
      @(posedge clk_i) disable iff (!rst_n_i)
      (micro_instr_reg_i[3:0] == 4'h5 && !cond_i[5]) |=> bit_test_o;
   endproperty
   a_rq14_clear: assert property (p_rq14_clear) else $error("protect clear wrong"); // [RQ14]

   property p_rq10;
      @(posedge clk_i) disable iff (!rst_n_i)
      (micro_instr_reg_i[3:0] == 4'h3) |=> (bit_test_o == $past(cond_i[3]));
   endproperty
   a_rq10: assert property (p_rq10) else $error("plain condition lost"); // [RQ9] [RQ10]

   property p_rq6;
      @(posedge clk_i) disable iff (!rst_n_i)
      !const_xform_enable_n_i |=>
         (kn_xform_o[31:24] == 8'h00 && kn_xform_o[7:0] == $past(micro_instr_reg_i[7:0]));
   endproperty
   a_rq6: assert property (p_rq6) else $error("const word sources wrong"); // [RQ6]

   property p_rq7;
      @(posedge clk_i) disable iff (!rst_n_i)
      !const_xform_enable_n_i |=> (kn_xform_o[23:16] == $past(second_selector_i));
   endproperty
   a_rq7: assert property (p_rq7) else $error("enabled transform idle"); // [RQ7]

   property p_rq5_acc;
      @(posedge clk_i) disable iff (!rst_n_i)
      (instr_transform_cmd_i && !instr_i[12] && instr_i[13] && !protect_violation_i) |=>
         dst_o == 3'h5;
   endproperty
   a_rq5_acc: assert property (p_rq5_acc) else $error("acc destination wrong"); // [RQ5]

   property p_rq2_add;
      @(posedge clk_i) disable iff (!rst_n_i)
      (instr_transform_cmd_i && !instr_i[12] && instr_i[9:8] == 2'b00) |=> fn_o == 5'h19;
   endproperty
   a_rq2_add: assert property (p_rq2_add) else $error("add code wrong"); // [RQ2]
endmodule : irxf_top
`default_nettype wire

// ==== test/irxf_seq_model.sv ====
/*
 * Model of the sequencer test multiplexer that consumes bit_test_o.
 * Assumes the bench supplies the test field decode of the current micro.
 */
`timescale 1ns/10ps
`default_nettype none
module irxf_seq_model (
   input wire logic bit_test_i,
   input wire logic bit_test_command_i,
   input wire logic other_test_i,
   output logic pick_upper_o
);
   // Selector output matters only under a bit-test command
   assign pick_upper_o = bit_test_command_i ? bit_test_i : other_test_i;
endmodule : irxf_seq_model
`default_nettype wire

// ==== test/irxf_top_test.sv ====
/*
 * Self-checking bench for irxf_top with the sequencer model.
 * Assumes one 200 MHz clock and outputs one cycle after inputs.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module irxf_top_test import irxf_pkg::*;;
   logic clk_i = 0, rst_n_i = 0, cmd = 0, prot = 0, en_n = 1, btcmd = 0, oth = 0;
   logic [15:0] instr = 0, xreg = 0, cond = 0;
   logic [7:0] ssel = 0;
   logic [31:0] micro_instr_reg = 0, kn;
   logic valid, org, norg, bt, pick;
   logic [4:0] fo;
   logic [2:0] ao, bo, dso;
   irxf_fields_s e;
   int fails = 0, checks_done = 0, cyc = 0;

   irxf_top dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .instr_transform_cmd_i(cmd),
      .instr_i(instr), .protect_violation_i(prot), .const_xform_enable_n_i(en_n),
      .second_selector_i(ssel), .index_transform_reg_i(xreg), .micro_instr_reg_i(micro_instr_reg),
      .cond_i(cond), .fn_o(fo), .a_src_o(ao), .b_src_o(bo), .dst_o(dso),
      .fields_valid_o(valid), .xform_origin_path_o(org), .xform_nonorigin_path_o(norg),
      .kn_xform_o(kn), .bit_test_o(bt));
   irxf_seq_model seq_u (.bit_test_i(bt), .bit_test_command_i(btcmd), .other_test_i(oth),
      .pick_upper_o(pick));

   // 5 ns clock
   initial forever #2.5 clk_i = ~clk_i;

   // Expected fields, codes written out independently of the package
   function automatic irxf_fields_s exp_f(input logic [15:0] in, input logic p);
      irxf_fields_s r;
      r = '{5'h1a, 3'h1, 3'h1, 3'h1};
      if (!in[12]) begin
         r.fn = in[9] ? (in[8] ? 5'h01 : 5'h09) : (in[8] ? 5'h0e : 5'h19);
         r.a_src = in[10] ? 3'h4 : 3'h6;
         r.b_src = in[11] ? 3'h4 : 3'h6;
         r.dst = in[13] ? 3'h5 : (in[14] ? 3'h3 : 3'h0);
      end
      if (p) r.dst = 3'h0;
      return r;
   endfunction : exp_f

   // One transform request, checked one edge later
   task automatic xf(input logic c, input logic [15:0] in, input logic p);
      @(posedge clk_i);
      cmd <= c;
      instr <= in;
      prot <= p;
      @(posedge clk_i);
      #1;
      e = c ? exp_f(in, p) : '0;
      `CHK("fields", e, {fo, ao, bo, dso})
      `CHK("valid", c, valid)
      if (c) `CHK("path", {~in[12], in[12]}, {org, norg})
   endtask : xf

   // Constant transform and bit-test selection
   task automatic misc(input logic [3:0] s, input logic [15:0] c, input logic [15:0] x,
                       input logic n);
      logic eb;
      @(posedge clk_i);
      micro_instr_reg <= {8'h3c, 16'h0000, 4'h9, s};
      cond <= c;
      xreg <= x;
      en_n <= n;
      ssel <= 8'hc3;
      btcmd <= s[0];
      oth <= s[1];
      @(posedge clk_i);
      #1;
      eb = (s == 4'h5) ? ~c[5] : (s == 4'ha) ? (x[15:8] == 8'h00) : c[s];
      `CHK("kn", n ? 32'h0000_0000 : {8'h00, 8'hc3, x[15:8], 4'h9, s}, kn)
      `CHK("bit", eb, bt)
      `CHK("pick", s[0] ? eb : s[1], pick)
   endtask : misc

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   // Hang guard, far above the expected run length
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         stop_test();
      end
   end

   // Main sequence; don't-care low bits held at ones in the 64-case sweep
   initial begin
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1;
      xf(1, 16'h1000, 0);
      xf(1, 16'hf0ff, 1);
      xf(0, 16'h2f00, 0);
      for (int i = 0; i < 64; i++) xf(1, {1'b0, i[5:4], 1'b0, i[3:0], 8'hff}, i[4] & i[1]);
      for (int s = 0; s < 16; s++) begin
         for (int k = 0; k < 2; k++) misc(s[3:0], k ? 16'ha5a5 : 16'h5a5a,
                                          k ? 16'h00ff : 16'h3400, k[0]);
      end
      stop_test();
   end
endmodule : irxf_top_test
`default_nettype wire
